// ---- rtl/serial_dda_integrator_core.sv ----
// Bit-serial integrator engine: 22 integrators time-share one adder pair.
// Assumes increments for the active section are valid on incIn at the
// section's first timing pulse, and a consumer drains outData.
//
// Summary of operation
// - 22 integrators take turns on one serial arithmetic section.
// - Integrand and remainder words are each 22 bits wide.
// - Integrand gains one on a present pulse, loses one when absent.
// - Remainder gains the integrand on a pulse, loses it otherwise.
// - Output increment is the remainder adder overflow.
// - Overflow tap bit sets remainder capacity, hence scale constant.
// - Every increment slot carries plus one as pulse, minus one as none.
// - Values live in recirculating serial stores feeding one adder pair.
// - Position counts modulo 48; its wrap steps section modulo 22.
// - Operands stream LSB first, equal weights in the same slot.
// - Remainder carry at the tap bit is emitted as output at the last section position.
`timescale 1ns/100ps
`default_nettype none

module serial_dda_integrator_core
  import dda_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire slot_in_s   incIn,
  input  wire logic [4:0] scaleTap,
  output logic [4:0]      sectionIdx,
  output logic [5:0]      position,
  output logic            outValid,
  input  wire logic       outReady,
  output incr_s           outData
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] integrandMem [NUM_INTEG];
  logic [WORD_W-1:0] remainderMem [NUM_INTEG];

  logic [3:0]  tickCnt_r, tickCnt_nxt;
  logic [5:0]  pos_r, pos_nxt;
  logic [4:0]  sect_r, sect_nxt;
  logic        dxHeld_r, dxHeld_nxt;
  logic        dyHeld_r, dyHeld_nxt;
  logic        yCarry_r, yCarry_nxt;
  logic        rCarry_r, rCarry_nxt;
  logic        ovf_r, ovf_nxt;
  logic        outValid_r, outValid_nxt;
  incr_s       outData_r, outData_nxt;

  logic        tick;
  logic        advance;
  logic        numeric;
  logic [4:0]  bitIdx;
  logic        yOld, yAdd, yCin, ySum, yCout;
  logic        rOld, rAdd, rCin, rSum, rCout;
  logic [WORD_W-1:0] yWordNxt, rWordNxt;
  logic        fifoInReady;
  logic        fifoPush;
  logic        fifoOutValid;
  logic        fifoPop;
  incr_s       fifoInData;
  incr_s       fifoOutData;

  // Full adder carry, used by both serial adders
  function automatic logic maj(input logic a, input logic b, input logic c);
    maj = (a & b) | (a & c) | (b & c);
  endfunction

  // ----------------------------------------------------------------
  // Timing pulse divider and stall
  // ----------------------------------------------------------------
  // Emit slot waits for FIFO room so no output increment is ever dropped
  assign tick     = (tickCnt_r == TICK_LAST);
  assign fifoPush = tick && (pos_r == EMIT_POS) && fifoInReady;
  assign advance  = tick && ((pos_r != EMIT_POS) || fifoInReady);

  always_comb begin
    tickCnt_nxt = tick ? 4'h0 : tickCnt_r + 4'h1;
  end

  // ----------------------------------------------------------------
  // Position and section counters
  // ----------------------------------------------------------------
  // Section index picks which stored integrator the shared adders serve
  always_comb begin
    pos_nxt  = pos_r;
    sect_nxt = sect_r;
    if (advance) begin
      if (pos_r == EMIT_POS) begin
        pos_nxt  = POS_RESET;
        if (sect_r == LAST_SECT) begin
          sect_nxt = SECT_RESET;
        end else begin
          sect_nxt = sect_r + 5'h01;
        end
      end else begin
        pos_nxt = pos_r + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Increment capture
  // ----------------------------------------------------------------
  // One slot per section: a pulse is plus one, no pulse is minus one
  always_comb begin
    dxHeld_nxt = dxHeld_r;
    dyHeld_nxt = dyHeld_r;
    if (advance && (pos_r == SAMPLE_POS)) begin
      dxHeld_nxt = incIn.independentIncrement;
      dyHeld_nxt = incIn.integrandIncrement;
    end
  end

  // ----------------------------------------------------------------
  // Serial arithmetic section
  // ----------------------------------------------------------------
  assign numeric = (pos_r >= NUM_FIRST) && (pos_r <= NUM_LAST);
  assign bitIdx  = 5'(pos_r - NUM_FIRST);

  // Both stores present their LSB in the same slot, so weights line up
  always_comb begin
    yOld  = integrandMem[sect_r][0];
    rOld  = remainderMem[sect_r][0];
    // Minus one is an all-ones addend; plus one is a carry-in of one
    yAdd  = ~dyHeld_r;
    yCin  = (bitIdx == 5'h00) ? dyHeld_r : yCarry_r;
    ySum  = yOld ^ yAdd ^ yCin;
    yCout = maj(yOld, yAdd, yCin);
    // Subtraction adds the complement of y plus one
    rAdd  = yOld ^ ~dxHeld_r;
    rCin  = (bitIdx == 5'h00) ? ~dxHeld_r : rCarry_r;
    rSum  = rOld ^ rAdd ^ rCin;
    rCout = maj(rOld, rAdd, rCin);
  end

  // Carries chain bit to bit; overflow is taken at the chosen tap
  always_comb begin
    yCarry_nxt = yCarry_r;
    rCarry_nxt = rCarry_r;
    ovf_nxt    = ovf_r;
    if (advance && numeric) begin
      yCarry_nxt = yCout;
      rCarry_nxt = rCout;
      if (bitIdx == scaleTap) begin
        ovf_nxt = rCout;
      end
    end
  end

  // Recirculate: LSB leaves, new bit enters at MSB, 22 shifts per pass
  always_comb begin
    yWordNxt = {ySum, integrandMem[sect_r][WORD_W-1:1]};
    // Bits above the tap are held at zero so capacity is 2^(tap+1)
    rWordNxt = {(bitIdx > scaleTap) ? 1'b0 : rSum,
                remainderMem[sect_r][WORD_W-1:1]};
  end

  // Serial stores; cleared at reset so every integrator starts from zero
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_INTEG; i++) begin
        integrandMem[i] <= '0;
        remainderMem[i] <= '0;
      end
    end else if (advance && numeric) begin
      integrandMem[sect_r] <= yWordNxt;
      remainderMem[sect_r] <= rWordNxt;
    end
  end

  // ----------------------------------------------------------------
  // Output buffering
  // ----------------------------------------------------------------
  assign fifoInData = '{section: sect_r, outputIncrement: ovf_r};

  incr_fifo #(
    .W     (INCR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .srst     (srst),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoPop),
    .outData  (fifoOutData)
  );

  // Output stage keeps every top output on a flop
  assign fifoPop = fifoOutValid && (!outValid_r || outReady);

  always_comb begin
    outValid_nxt = outValid_r;
    outData_nxt  = outData_r;
    if (fifoPop) begin
      outValid_nxt = 1'b1;
      outData_nxt  = fifoOutData;
    end else if (outReady) begin
      outValid_nxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      tickCnt_r  <= 4'h0;
      pos_r      <= POS_RESET;
      sect_r     <= SECT_RESET;
      dxHeld_r   <= 1'b0;
      dyHeld_r   <= 1'b0;
      yCarry_r   <= 1'b0;
      rCarry_r   <= 1'b0;
      ovf_r      <= 1'b0;
      outValid_r <= 1'b0;
      outData_r  <= '0;
    end else begin
      tickCnt_r  <= tickCnt_nxt;
      pos_r      <= pos_nxt;
      sect_r     <= sect_nxt;
      dxHeld_r   <= dxHeld_nxt;
      dyHeld_r   <= dyHeld_nxt;
      yCarry_r   <= yCarry_nxt;
      rCarry_r   <= rCarry_nxt;
      ovf_r      <= ovf_nxt;
      outValid_r <= outValid_nxt;
      outData_r  <= outData_nxt;
    end
  end

  assign sectionIdx = sect_r;
  assign position   = pos_r;
  assign outValid   = outValid_r;
  assign outData    = outData_r;

endmodule // serial_dda_integrator_core

`default_nettype wire

// ---- rtl/dda_pkg.sv ----
// Shared constants and carriers for the bit-serial integrator engine.
// Assumes a single 10 MHz clock and synchronous active-high reset.
package dda_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_INTEG   = 22;
  localparam int unsigned WORD_W      = 22;
  localparam int unsigned SECT_LEN    = 48;
  localparam logic [5:0]  SAMPLE_POS  = 6'h00;
  localparam logic [5:0]  NUM_FIRST   = 6'h18;
  localparam logic [5:0]  NUM_LAST    = 6'h2d;
  localparam logic [5:0]  EMIT_POS    = 6'h2f;
  localparam logic [4:0]  LAST_SECT   = 5'h15;
  localparam logic [5:0]  POS_RESET   = 6'h00;
  localparam logic [4:0]  SECT_RESET  = 5'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned PULSE_PERIOD_NS = 400;
  localparam int unsigned TICK_DIV = PULSE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  TICK_LAST = 4'(TICK_DIV - 1);

  // ----------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic independentIncrement;
    logic integrandIncrement;
  } slot_in_s;

  typedef struct packed {
    logic [4:0] section;
    logic       outputIncrement;
  } incr_s;

  localparam int unsigned INCR_W = $bits(incr_s);

endpackage : dda_pkg

// ---- rtl/incr_fifo.sv ----
// Small synchronous FIFO for output increment words.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module incr_fifo #(
  parameter int unsigned W     = 6,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wrPtr_r, wrPtr_nxt;
  logic [PW-1:0] rdPtr_r, rdPtr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Flags and pointers
  // ----------------------------------------------------------------
  assign inReady  = (count_r != FULL_CNT);
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Next pointer and occupancy values
  always_comb begin
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    count_nxt = count_r;
    if (push) begin
      wrPtr_nxt = (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
    end
    if (pop) begin
      rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // Registers; storage itself needs no reset since count gates reads
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

endmodule // incr_fifo

`default_nettype wire

// ---- verification/dda_core_properties.sv ----
// Port checker for the bit-serial integrator engine.
// Assumes dda_pkg constants and the single clk domain.
`timescale 1ns/100ps
`default_nettype none
module dda_core_properties
  import dda_pkg::*;
(
  input wire logic       clk,
  input wire logic       srst,
  input wire slot_in_s   incIn,
  input wire logic [4:0] scaleTap,
  input wire logic [4:0] sectionIdx,
  input wire logic [5:0] position,
  input wire logic       outValid,
  input wire logic       outReady,
  input wire incr_s      outData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----
  // Sequencing
  // ----
  a_pos_step: assert property ($changed(position) |->
    position == (($past(position) == EMIT_POS) ? POS_RESET
                 : $past(position) + 6'h01)) else $error("position step");
  a_sect_wrap: assert property ($changed(sectionIdx) |->
    $past(position) == EMIT_POS && sectionIdx == (($past(sectionIdx) ==
    LAST_SECT) ? SECT_RESET : $past(sectionIdx) + 5'h01))
    else $error("section step");
  a_tick_hold: assert property ($changed(position) |=>
    $stable(position)[*3]) else $error("slot period short");
  // Only the emit slot may stall, when the buffer is full
  a_pos_advance: assert property (position != EMIT_POS |->
    ##[1:4] $changed(position)) else $error("slot period long");
  a_count_range: assert property (position <= EMIT_POS &&
    sectionIdx <= LAST_SECT) else $error("counter range");
  a_valid_hold: assert property (outValid && !outReady |=>
    outValid && $stable(outData)) else $error("word dropped");
  a_emit_slot: assert property ($rose(outValid) |->
    $past(position, 2) == EMIT_POS) else $error("word off slot");
  a_reset_clear: assert property (disable iff (1'b0) srst |=>
    position == POS_RESET && sectionIdx == SECT_RESET && !outValid)
    else $error("reset state");
  c_accept: cover property (outValid && outReady);
  c_stall: cover property (position == EMIT_POS && !outReady);
  c_wrap: cover property (sectionIdx == LAST_SECT ##[1:300] !sectionIdx);
endmodule // dda_core_properties
bind serial_dda_integrator_core dda_core_properties chk_u (.clk(clk),
  .srst(srst), .incIn(incIn), .scaleTap(scaleTap), .sectionIdx(sectionIdx),
  .position(position), .outValid(outValid), .outReady(outReady),
  .outData(outData));
`default_nettype wire

// ---- verification/incr_source.sv ----
// Model of the upstream integrators that feed increment slots.
// Assumes the bench gives one slot pair per section in pattern.
`timescale 1ns/100ps
`default_nettype none
module incr_source
  import dda_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [43:0] pattern,
  input  wire logic [4:0]  sectionIdx,
  output var slot_in_s     incIn
);
  // ----
  // Slot driver
  // ----
  // Off the sampling edge, so the engine never sees a changing slot
  always @(negedge clk) begin
    incIn <= pattern[2*sectionIdx +: 2];
  end
endmodule // incr_source
`default_nettype wire

// ---- verification/serial_dda_integrator_core_tb.sv ----
// Self-checking bench for the bit-serial integrator engine.
// Assumes incr_source supplies slots; the bench drains the words.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module serial_dda_integrator_core_tb
  import dda_pkg::*;
;
  // ----
  // Signals and reference state
  // ----
  logic        clk, srst, outReady, outValid, dx, dy;
  logic [4:0]  scaleTap, sectionIdx, expSect;
  logic [5:0]  position;
  logic [43:0] pattern;
  logic [22:0] sum, mask, op;
  logic [21:0] yAcc [22];
  logic [21:0] rAcc [22];
  slot_in_s    incIn;
  incr_s       outData;
  int          failures, comparisons, cyc, words, n;
  // Rows: dx, dy, first-pass output from cleared stores
  logic [2:0]  rows [4] = '{3'h6, 3'h3, 3'h4, 3'h1};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  serial_dda_integrator_core dut_u (.clk(clk), .srst(srst), .incIn(incIn),
    .scaleTap(scaleTap), .sectionIdx(sectionIdx), .position(position),
    .outValid(outValid), .outReady(outReady), .outData(outData));
  incr_source src_u (.clk(clk), .pattern(pattern), .sectionIdx(sectionIdx),
    .incIn(incIn));

  task automatic complete_run();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Reference integrators, stepped on every accepted word
  always @(posedge clk) begin
    cyc++;
    if (srst) begin
      expSect = '0;
      for (int s = 0; s < 22; s++) begin
        yAcc[s] = '0;
        rAcc[s] = '0;
      end
    end else if (outValid && outReady) begin
      `CHK("section", expSect, outData.section)
      {dx, dy} = pattern[2*expSect +: 2];
      mask = (23'h1 << (scaleTap + 1)) - 23'h1;
      op = dx ? {1'b0, yAcc[expSect]} : {1'b0, ~yAcc[expSect]};
      sum = ({1'b0, rAcc[expSect]} & mask) + (op & mask) + {22'h0, !dx};
      `CHK("ovf", sum[scaleTap + 1], outData.outputIncrement)
      rAcc[expSect] = sum[21:0] & mask[21:0];
      yAcc[expSect] = yAcc[expSect] + (dy ? 22'h1 : 22'h3fffff);
      expSect = (expSect == LAST_SECT) ? 5'h0 : expSect + 5'h1;
      words++;
    end
    if (cyc == 50000) begin
      failures++;
      complete_run();
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    srst = 1'b1;
    outReady = 1'b1;
    scaleTap = 5'h02;
    pattern = '0;
    failures = 0;
    comparisons = 0;
    cyc = 0;
    words = 0;
    for (int s = 0; s < 22; s++) pattern[2*s +: 2] = rows[s % 4][2:1];
    repeat (20) @(negedge clk);
    `CHK("rst pos", POS_RESET, position)
    `CHK("rst valid", 1'b0, outValid)
    srst = 1'b0;
    // First pass from cleared stores, one row per section
    for (int s = 0; s < 22; s++) begin
      do @(negedge clk); while (!(outValid && outReady));
      `CHK("first", rows[s % 4][0], outData.outputIncrement)
    end
    wait (words >= 66);
    // Consumer stalls: buffer fills and the engine holds at emit slot
    @(negedge clk);
    outReady = 1'b0;
    repeat (2304) @(negedge clk);
    `CHK("stall pos", EMIT_POS, position)
    `CHK("stall valid", 1'b1, outValid)
    outReady = 1'b1;
    wait (words >= 110);
    // Reset in mid-run, then the narrowest overflow tap
    @(negedge clk);
    srst = 1'b1;
    @(negedge clk);
    `CHK("mid pos", POS_RESET, position)
    `CHK("mid sect", SECT_RESET, sectionIdx)
    srst = 1'b0;
    scaleTap = 5'h00;
    n = words;
    wait (words >= n + 44);
    complete_run();
  end
endmodule // serial_dda_integrator_core_tb
`default_nettype wire
